// ### src/fdr_pkg.sv
// Register map, field layout, reset values and timing of the flash driver bank
package fdr_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [3:0] ADDR_ID    = 4'h0;
  localparam logic [3:0] ADDR_CUR   = 4'h1;
  localparam logic [3:0] ADDR_TXM   = 4'h3;
  localparam logic [3:0] ADDR_LOWV  = 4'h4;
  localparam logic [3:0] ADDR_FTIM  = 4'h5;
  localparam logic [3:0] ADDR_CTRL  = 4'h6;
  localparam logic [3:0] ADDR_STRB  = 4'h7;
  localparam logic [3:0] ADDR_FAULT = 4'h8;
  localparam logic [3:0] ADDR_PWM   = 4'h9;
  localparam logic [3:0] ADDR_MIN   = 4'hE;
  localparam logic [3:0] ADDR_ACT   = 4'hF;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CUR   = 8'h9C;
  localparam logic [7:0] RST_TXM   = 8'h68;
  localparam logic [7:0] RST_LOWV  = 8'h2C;
  localparam logic [7:0] RST_FTIM  = 8'h23;
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_STRB  = 8'hC0;
  localparam logic [7:0] RST_FAULT = 8'h00;
  localparam logic [7:0] RST_PWM   = 8'h00;
  localparam logic [7:0] RST_MIN   = 8'h00;
  localparam logic [7:0] RST_ACT   = 8'h00;
  // ==========================================================
  // Implemented bits of each register
  localparam logic [7:0] MASK_FULL  = 8'hFF;
  localparam logic [7:0] MASK_CTRL  = 8'h0B;
  localparam logic [7:0] MASK_STRB  = 8'hC0;
  localparam logic [7:0] MASK_FAULT = 8'hF9;
  localparam logic [7:0] MASK_PWM   = 8'h07;
  // ==========================================================
  // Field positions
  localparam int BIT_CONSTV    = 7;
  localparam int BIT_OUT_ON    = 3;
  localparam int BIT_FREQ_SW   = 2;
  localparam int BIT_STRB_ON   = 7;
  localparam int BIT_STRB_TYPE = 6;
  localparam int BIT_FLT_UVLO  = 0;
  localparam int MODE_LSB      = 0;
  localparam int DUTY_LSB      = 0;
  localparam logic [7:0] CUR_NOSKIP_MIN = 8'h40;
  // ==========================================================
  // Timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int PWM_FREQ_HZ  = 31_250;
  localparam int PWM_STEPS    = 16;
  localparam int PWM_SLOT_CYC = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
  // ==========================================================
  // Operating modes
  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_IND    = 2'b01,
    MODE_ASSIST = 2'b11,
    MODE_FLASH  = 2'b10
  } fdr_mode_t;
endpackage : fdr_pkg

// ### src/fdr_ctrl_if.sv
// Control signals shared between the register bank and its output stages
`timescale 1ns/100ps
interface fdr_ctrl_if;
  fdr_pkg::fdr_mode_t mode;
  logic [1:0]         duty;
  logic               freq_sw;
  logic [7:0]         current;
  logic               sink_en;
  logic               pwm_on;
  logic               skip_dis;
  modport bank (output mode, duty, freq_sw, current, sink_en, input pwm_on, skip_dis);
  modport pwm  (input mode, duty, sink_en, output pwm_on);
  modport conv (input mode, freq_sw, current, sink_en, output skip_dis);
endinterface : fdr_ctrl_if

// ### src/fdr_pwm.sv
// Indicator PWM generator, 16 slots per period
`timescale 1ns/100ps
module fdr_pwm #(
  parameter int SLOT_CYC = fdr_pkg::PWM_SLOT_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  fdr_ctrl_if.pwm   ctl
);
  if (SLOT_CYC < 1 || SLOT_CYC > 65535) begin : g_bad_slot
    $error("SLOT_CYC out of range");
  end

  logic [15:0] slot_cnt_reg;
  logic [3:0]  step_reg;
  logic        pwm_on_reg;
  logic        tick;

  assign tick       = (slot_cnt_reg == 16'(SLOT_CYC - 1));
  assign ctl.pwm_on = pwm_on_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset || tick) begin
      slot_cnt_reg <= 16'h0000;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      step_reg <= 4'h0;
    end else if (tick) begin
      step_reg <= step_reg + 4'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pwm_on_reg <= 1'b0;
    end else begin
      pwm_on_reg <= ctl.sink_en && (ctl.mode == fdr_pkg::MODE_IND) &&
                    (step_reg <= {2'b00, ctl.duty});
    end
  end

  chk_pwm_mode_gate: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ctl.mode != fdr_pkg::MODE_IND |=> !pwm_on_reg)
    else $error("pwm active outside indicator mode");
  chk_pwm_duty_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    step_reg > {2'b00, ctl.duty} |=> !pwm_on_reg)
    else $error("pwm high beyond duty slot");
endmodule : fdr_pwm

// ### src/fdr_conv.sv
// Converter pulse-skip control
`timescale 1ns/100ps
module fdr_conv (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  fdr_ctrl_if.conv  ctl
);
  logic skip_dis_reg;
  logic hi_mode;

  assign hi_mode      = (ctl.mode == fdr_pkg::MODE_FLASH) || (ctl.mode == fdr_pkg::MODE_ASSIST);
  assign ctl.skip_dis = skip_dis_reg;

  // pulse-skip only off at high current
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      skip_dis_reg <= 1'b0;
    end else begin
      skip_dis_reg <= ctl.sink_en && ctl.freq_sw && hi_mode &&
                      (ctl.current >= fdr_pkg::CUR_NOSKIP_MIN);
    end
  end

  chk_conv_ind_skip: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ctl.mode == fdr_pkg::MODE_IND |=> !skip_dis_reg)
    else $error("pulse-skip disabled in indicator mode");
  chk_conv_sw_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !ctl.freq_sw |=> !skip_dis_reg)
    else $error("pulse-skip disabled with switch bit clear");
  chk_conv_sw_on: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ctl.sink_en && ctl.freq_sw && hi_mode && ctl.current >= fdr_pkg::CUR_NOSKIP_MIN
    |=> skip_dis_reg)
    else $error("pulse-skip not disabled at high current");
endmodule : fdr_conv

// ### src/fdr_regs.sv
// Register bank of the two-sink flash driver with status and PWM control
`timescale 1ns/100ps
// Summary of operation
// - Fault bits return captured value on read, then clear themselves.
// - Indicator mode pulses sinks at 31.25kHz with duty (code+1)/16.
// - Switch bit clear allows pulse-skip in every mode.
// - Switch bit set, sinks enabled, flash/assist, current 40h up: pulse-skip off.
// - Indicator operation always uses pulse-skip.
// - Minimum-current report holds lowest undervoltage-reduced current since the latest cycle start.
// - Minimum report loads only on real undervoltage reduction, else zero.
// - Actual-current report shows currently applied sink current.
// - Constant-voltage mode holds sinks off and blocks all requests.
// - Strobe type bit selects edge or level sensing.
module fdr_regs #(
  parameter logic [7:0] CHIP_ID  = 8'hA5, // Arbitrary identity value
  parameter int         SLOT_CYC = fdr_pkg::PWM_SLOT_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic [3:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  input  wire logic [7:0] i_fault_set,
  input  wire logic       i_cycle_start,
  input  wire logic       i_uv_reduce,
  input  wire logic [7:0] i_uv_current,
  input  wire logic [7:0] i_actual_current,
  input  wire logic       i_strobe,
  output logic            o_strobe_req,
  output logic            o_sink_enable,
  output logic            o_sink_on,
  output logic            o_pulse_skip_dis,
  output logic      [1:0] o_mode,
  output logic      [7:0] o_led_current,
  output logic      [7:0] o_txmask_cfg,
  output logic      [7:0] o_low_voltage_cfg,
  output logic      [7:0] o_flash_timer_cfg
);
  // ==========================================================
  // Storage
  logic [7:0] cur_reg;
  logic [7:0] txm_reg;
  logic [7:0] lowv_reg;
  logic [7:0] ftim_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] strb_reg;
  logic [7:0] pwm_reg;
  logic [7:0] fault_reg;
  logic [7:0] fault_next;
  logic [7:0] min_reg;
  logic       min_seen_reg;
  logic [7:0] act_reg;
  logic [7:0] rdata_reg;
  logic       strobe_prev_reg;
  logic       strobe_req_reg;
  logic [7:0] fault_in;
  logic       const_v;
  logic       rd_fault;

  fdr_ctrl_if ctl ();

  // Write mask for each address; zero where not writable
  function automatic logic [7:0] wr_mask(input logic [3:0] a);
    case (a)
      fdr_pkg::ADDR_CUR, fdr_pkg::ADDR_TXM,
      fdr_pkg::ADDR_LOWV, fdr_pkg::ADDR_FTIM: wr_mask = fdr_pkg::MASK_FULL;
      fdr_pkg::ADDR_CTRL: wr_mask = fdr_pkg::MASK_CTRL;
      fdr_pkg::ADDR_STRB: wr_mask = fdr_pkg::MASK_STRB;
      fdr_pkg::ADDR_PWM:  wr_mask = fdr_pkg::MASK_PWM;
      default:            wr_mask = 8'h00;
    endcase
  endfunction : wr_mask

  // ==========================================================
  // Host writes
  // masked writes, read-only ignored
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cur_reg  <= fdr_pkg::RST_CUR;
      txm_reg  <= fdr_pkg::RST_TXM;
      lowv_reg <= fdr_pkg::RST_LOWV;
      ftim_reg <= fdr_pkg::RST_FTIM;
      ctrl_reg <= fdr_pkg::RST_CTRL;
      strb_reg <= fdr_pkg::RST_STRB;
      pwm_reg  <= fdr_pkg::RST_PWM;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        fdr_pkg::ADDR_CUR:  cur_reg  <= i_reg_wdata;
        fdr_pkg::ADDR_TXM:  txm_reg  <= i_reg_wdata;
        fdr_pkg::ADDR_LOWV: lowv_reg <= i_reg_wdata;
        fdr_pkg::ADDR_FTIM: ftim_reg <= i_reg_wdata;
        fdr_pkg::ADDR_CTRL: ctrl_reg <= i_reg_wdata & wr_mask(i_reg_addr);
        fdr_pkg::ADDR_STRB: strb_reg <= i_reg_wdata & wr_mask(i_reg_addr);
        fdr_pkg::ADDR_PWM:  pwm_reg  <= i_reg_wdata & wr_mask(i_reg_addr);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Host reads
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_reg <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        fdr_pkg::ADDR_ID:    rdata_reg <= CHIP_ID;
        fdr_pkg::ADDR_CUR:   rdata_reg <= cur_reg;
        fdr_pkg::ADDR_TXM:   rdata_reg <= txm_reg;
        fdr_pkg::ADDR_LOWV:  rdata_reg <= lowv_reg;
        fdr_pkg::ADDR_FTIM:  rdata_reg <= ftim_reg;
        fdr_pkg::ADDR_CTRL:  rdata_reg <= ctrl_reg;
        fdr_pkg::ADDR_STRB:  rdata_reg <= strb_reg;
        fdr_pkg::ADDR_FAULT: rdata_reg <= fault_reg;
        fdr_pkg::ADDR_PWM:   rdata_reg <= pwm_reg;
        fdr_pkg::ADDR_MIN:   rdata_reg <= min_reg;
        fdr_pkg::ADDR_ACT:   rdata_reg <= act_reg;
        default:             rdata_reg <= 8'h00;
      endcase
    end
  end

  assign o_reg_rdata = rdata_reg;

  // ==========================================================
  // Fault flags
  assign rd_fault = i_reg_rd && (i_reg_addr == fdr_pkg::ADDR_FAULT);
  assign fault_in = (i_fault_set | {7'h00, i_uv_reduce}) & fdr_pkg::MASK_FAULT;

  // clear after read, new events win
  always_comb begin
    fault_next = fault_reg;
    if (rd_fault) begin
      fault_next = 8'h00;
    end
    fault_next = fault_next | fault_in;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      fault_reg <= fdr_pkg::RST_FAULT;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // ==========================================================
  // Current reports
  // lowest reduced current, zero if none
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      min_reg      <= fdr_pkg::RST_MIN;
      min_seen_reg <= 1'b0;
    end else if (i_uv_reduce) begin
      min_seen_reg <= 1'b1;
      if (i_cycle_start || !min_seen_reg || i_uv_current < min_reg) begin
        min_reg <= i_uv_current;
      end
    end else if (i_cycle_start) begin
      min_reg      <= fdr_pkg::RST_MIN;
      min_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      act_reg <= fdr_pkg::RST_ACT;
    end else begin
      act_reg <= i_actual_current;
    end
  end

  // ==========================================================
  // Strobe sensing
  assign const_v = lowv_reg[fdr_pkg::BIT_CONSTV];

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      strobe_prev_reg <= 1'b0;
    end else begin
      strobe_prev_reg <= i_strobe;
    end
  end

  // edge or level, blocked in constant-voltage mode
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      strobe_req_reg <= 1'b0;
    end else if (!strb_reg[fdr_pkg::BIT_STRB_ON] || const_v) begin
      strobe_req_reg <= 1'b0;
    end else if (strb_reg[fdr_pkg::BIT_STRB_TYPE]) begin
      strobe_req_reg <= i_strobe;
    end else begin
      strobe_req_reg <= i_strobe && !strobe_prev_reg;
    end
  end

  assign o_strobe_req = strobe_req_reg;

  // ==========================================================
  // Output stages
  assign ctl.mode    = fdr_pkg::fdr_mode_t'(ctrl_reg[fdr_pkg::MODE_LSB +: 2]);
  assign ctl.duty    = pwm_reg[fdr_pkg::DUTY_LSB +: 2];
  assign ctl.freq_sw = pwm_reg[fdr_pkg::BIT_FREQ_SW];
  assign ctl.current = cur_reg;
  assign ctl.sink_en = ctrl_reg[fdr_pkg::BIT_OUT_ON] && !const_v;

  fdr_pwm #(
    .SLOT_CYC (SLOT_CYC)
  ) u_pwm (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .ctl       (ctl.pwm)
  );

  fdr_conv u_conv (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .ctl       (ctl.conv)
  );

  // indicator mode uses PWM gate, all gated by sink enable
  assign o_sink_on = ctl.sink_en &&
                     ((ctl.mode == fdr_pkg::MODE_IND) ? ctl.pwm_on :
                      (ctl.mode != fdr_pkg::MODE_OFF));
  assign o_sink_enable     = ctl.sink_en;
  assign o_pulse_skip_dis  = ctl.skip_dis;
  assign o_mode            = ctrl_reg[fdr_pkg::MODE_LSB +: 2];
  assign o_led_current     = cur_reg;
  assign o_txmask_cfg      = txm_reg;
  assign o_low_voltage_cfg = lowv_reg;
  assign o_flash_timer_cfg = ftim_reg;

  // ==========================================================
  // Checks
  sequence s_strobe_rise;
    !i_strobe ##1 i_strobe;
  endsequence

  sequence s_cycle_clear;
    i_cycle_start && !i_uv_reduce ##1 !i_uv_reduce [*2];
  endsequence

  chk_fault_self_clear: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    rd_fault && fault_in == 8'h00 |=> fault_reg == 8'h00 && o_reg_rdata == $past(fault_reg))
    else $error("fault register not cleared after read");
  chk_fault_pending: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    fault_in != 8'h00 |=> (fault_reg & $past(fault_in)) == $past(fault_in))
    else $error("fault event lost");
  chk_rdata_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");

  chk_min_zero: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    s_cycle_clear |-> min_reg == 8'h00)
    else $error("minimum report nonzero without reduction");
  chk_min_load: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_uv_reduce && (i_cycle_start || !min_seen_reg) |=> min_reg == $past(i_uv_current))
    else $error("minimum report not loaded on first reduction");
  chk_min_lowest: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_uv_reduce && min_seen_reg && !i_cycle_start |=> min_reg <= $past(min_reg))
    else $error("minimum report rose within a cycle");
  chk_act_follow: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    1'b1 |=> act_reg == $past(i_actual_current))
    else $error("actual current report not following sink stage");

  chk_constv_block: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    const_v |-> !o_sink_on && !o_sink_enable)
    else $error("sinks active in constant-voltage mode");
  chk_constv_strobe: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    const_v |=> !o_strobe_req)
    else $error("strobe request in constant-voltage mode");
  chk_sink_gate: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !o_sink_enable |-> !o_sink_on)
    else $error("sink driven while disabled");
  chk_strobe_edge: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    s_strobe_rise ##1 i_strobe && !strb_reg[fdr_pkg::BIT_STRB_TYPE] &&
    strb_reg[fdr_pkg::BIT_STRB_ON] && !const_v |=> !o_strobe_req)
    else $error("edge mode strobe request held");
  chk_strobe_level: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    strb_reg[fdr_pkg::BIT_STRB_ON] && strb_reg[fdr_pkg::BIT_STRB_TYPE] && !const_v
    |=> o_strobe_req == $past(i_strobe))
    else $error("level mode strobe request not following input");
  chk_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_reg_rd && i_reg_addr == fdr_pkg::ADDR_CTRL |=> (o_reg_rdata & ~fdr_pkg::MASK_CTRL) == 8'h00)
    else $error("reserved control bits read nonzero");
  chk_pwm_mask: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_reg_wr && i_reg_addr == fdr_pkg::ADDR_PWM |=> (pwm_reg & ~fdr_pkg::MASK_PWM) == 8'h00)
    else $error("reserved indicator bits stored");
  chk_ro_write: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_reg_wr && wr_mask(i_reg_addr) == 8'h00 |=>
    $stable({cur_reg, txm_reg, lowv_reg, ftim_reg, ctrl_reg, strb_reg, pwm_reg}))
    else $error("write to read-only register altered state");
endmodule : fdr_regs

// ### dv/fdr_host_model.sv
// Host model that drives the register strobe port of the bank
`timescale 1ns/100ps
module fdr_host_model (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_reg_rdata,
  output logic      [3:0] o_reg_addr,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [7:0] o_reg_wdata
);
  initial begin
    o_reg_addr  = 4'h0;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_wdata = 8'h00;
  end
  // ==========================================================
  // Bus cycles
  // undefined bits zero
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge i_clk_sys);
    o_reg_wr    <= 1'b1;
    o_reg_addr  <= a;
    o_reg_wdata <= d & m;
    @(posedge i_clk_sys);
    o_reg_wr    <= 1'b0;
    o_reg_addr  <= ~a;
    o_reg_wdata <= ~(d & m);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_reg_rd   <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_clk_sys);
    o_reg_rd   <= 1'b0;
    o_reg_addr <= ~a;
    #1;
    d = i_reg_rdata;
  endtask : rd
  task automatic rd_twice(input logic [3:0] a, output logic [7:0] d);
    logic [7:0] e;
    rd(a, e);
    rd(a, d);
    for (int i = 0; i < 4 && d !== e; i++) begin
      e = d;
      rd(a, d);
    end
  endtask : rd_twice
endmodule : fdr_host_model

// ### dv/flash_driver_status_pwm_regs_bench.sv
// Self-checking bench of the flash driver register bank
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("mismatch t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end
module flash_driver_status_pwm_regs_bench;
  localparam logic [7:0] ID_VAL = 8'h5A; // Arbitrary identity value
  localparam int         SLOT   = 2;
  localparam int         LIMIT  = 20000;
  logic       clk;
  logic       reset;
  logic [7:0] fault_set;
  logic       cycle_start;
  logic       uv_reduce;
  logic [7:0] uv_current;
  logic [7:0] actual_current;
  logic       strobe;
  wire  [3:0] addr;
  wire        wr;
  wire        rd;
  wire  [7:0] wdata;
  wire  [7:0] rdata;
  wire        strobe_req;
  wire        sink_enable;
  wire        sink_on;
  wire        skip_dis;
  wire  [1:0] mode;
  wire  [7:0] led_cur;
  wire  [7:0] txm_cfg;
  wire  [7:0] lowv_cfg;
  wire  [7:0] ftim_cfg;
  int         bad_count;
  int         checked;
  int         cycles;
  fdr_regs #(.CHIP_ID(ID_VAL), .SLOT_CYC(SLOT)) u_dut (
    .i_clk_sys(clk), .i_reset(reset), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_fault_set(fault_set),
    .i_cycle_start(cycle_start), .i_uv_reduce(uv_reduce), .i_uv_current(uv_current),
    .i_actual_current(actual_current), .i_strobe(strobe), .o_strobe_req(strobe_req),
    .o_sink_enable(sink_enable), .o_sink_on(sink_on), .o_pulse_skip_dis(skip_dis),
    .o_mode(mode), .o_led_current(led_cur), .o_txmask_cfg(txm_cfg),
    .o_low_voltage_cfg(lowv_cfg), .o_flash_timer_cfg(ftim_cfg)
  );
  fdr_host_model u_host (
    .i_clk_sys(clk), .i_reg_rdata(rdata), .o_reg_addr(addr), .o_reg_wr(wr),
    .o_reg_rd(rd), .o_reg_wdata(wdata)
  );
  always #5 clk = ~clk;
  // ==========================================================
  // Helpers
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      print_verdict();
    end
  end
  // Counts high cycles of sink, strobe request and skip disable
  task automatic cnt(input int n, output int ns, output int nq, output int nk);
    ns = 0;
    nq = 0;
    nk = 0;
    repeat (n) begin
      @(negedge clk);
      ns += (sink_on !== 1'b0);
      nq += (strobe_req !== 1'b0);
      nk += (skip_dis !== 1'b0);
    end
  endtask : cnt
  // ==========================================================
  // Scenarios
  task automatic t_reset_vals;
    logic [7:0] d;
    logic [7:0] tab [16] = '{ID_VAL, 8'h9C, 8'h00, 8'h68, 8'h2C, 8'h23, 8'h00, 8'hC0,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int a = 0; a < 16; a++) begin
      u_host.rd(a[3:0], d);
      `CHK(d, tab[a])
    end
    `CHK(({mode, led_cur, txm_cfg, lowv_cfg, ftim_cfg}), ({2'b00, 32'h9C682C23}))
    `CHK(({sink_enable, sink_on, skip_dis, strobe_req}), 4'h0)
  endtask : t_reset_vals
  task automatic t_rw_mask;
    logic [7:0] d;
    logic [3:0] wa [11] = '{1, 3, 5, 7, 9, 6, 0, 2, 8, 14, 15};
    logic [7:0] wd [11] = '{8'h55, 8'hA7, 8'h3C, 8'h40, 8'h06, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                            8'hFF, 8'hFF};
    logic [7:0] we [11] = '{8'h55, 8'hA7, 8'h3C, 8'h40, 8'h06, 8'h0B, ID_VAL, 8'h00, 8'h00,
                            8'h00, 8'h00};
    for (int i = 0; i < 11; i++) begin
      u_host.wr(wa[i], wd[i], 8'hFF);
    end
    for (int i = 0; i < 11; i++) begin
      u_host.rd(wa[i], d);
      `CHK(d, we[i])
    end
    `CHK(skip_dis, 1'b1)
    `CHK(({mode, led_cur, txm_cfg, lowv_cfg, ftim_cfg}), ({2'b11, 32'h55A72C3C}))
  endtask : t_rw_mask
  task automatic t_fault;
    logic [7:0] d;
    @(posedge clk);
    fault_set <= 8'hFF;
    @(posedge clk);
    fault_set <= 8'h00;
    u_host.rd(4'h8, d);
    `CHK(d, 8'hF9)
    u_host.rd(4'h8, d);
    `CHK(d, 8'h00)
    fork
      u_host.rd(4'h8, d);
      begin
        @(posedge clk);
        fault_set <= 8'h10;
        @(posedge clk);
        fault_set <= 8'h00;
      end
    join
    `CHK(d, 8'h00)
    u_host.rd(4'h8, d);
    `CHK(d, 8'h10)
  endtask : t_fault
  task automatic t_min_cur;
    logic [7:0] d;
    @(posedge clk);
    cycle_start <= 1'b1;
    @(posedge clk);
    cycle_start <= 1'b0;
    uv_reduce   <= 1'b1;
    uv_current  <= 8'h50;
    @(posedge clk);
    uv_current <= 8'h30;
    @(posedge clk);
    uv_current <= 8'h60;
    @(posedge clk);
    uv_reduce  <= 1'b0;
    uv_current <= 8'hCF;
    u_host.rd(4'hE, d);
    `CHK(d, 8'h30)
    u_host.rd(4'h8, d);
    `CHK(d, 8'h01)
    @(posedge clk);
    cycle_start <= 1'b1;
    @(posedge clk);
    cycle_start <= 1'b0;
    u_host.rd(4'hE, d);
    `CHK(d, 8'h00)
  endtask : t_min_cur
  task automatic t_act_cur;
    logic [7:0] d;
    @(posedge clk);
    actual_current <= 8'h7A;
    u_host.rd_twice(4'hF, d);
    `CHK(d, 8'h7A)
  endtask : t_act_cur
  task automatic t_pwm;
    int ns;
    int nq;
    int nk;
    u_host.wr(4'h1, 8'h9C, 8'hFF);
    u_host.wr(4'h6, 8'h09, 8'h0B);
    for (int d = 0; d < 4; d++) begin
      u_host.wr(4'h9, {5'h00, 1'b1, d[1:0]}, 8'h07);
      repeat (40) @(posedge clk);
      cnt(16 * SLOT, ns, nq, nk);
      `CHK(ns, (d + 1) * SLOT)
      `CHK(nk, 0)
    end
  endtask : t_pwm
  task automatic t_skip;
    logic [1:0] md [5] = '{2'b10, 2'b11, 2'b10, 2'b11, 2'b00};
    logic [7:0] cu [5] = '{8'h40, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
    logic       fs [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic       ex [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++) begin
      u_host.wr(4'h1, cu[i], 8'hFF);
      u_host.wr(4'h9, {5'h00, fs[i], 2'b00}, 8'h07);
      u_host.wr(4'h6, {6'h02, md[i]}, 8'h0B);
      repeat (3) @(posedge clk);
      #1;
      `CHK(skip_dis, ex[i])
    end
  endtask : t_skip
  task automatic t_constv;
    int ns;
    int nq;
    int nk;
    u_host.wr(4'h7, 8'hC0, 8'hC0);
    u_host.wr(4'h4, 8'hAC, 8'hFF);
    u_host.wr(4'h9, 8'h04, 8'h07);
    u_host.wr(4'h6, 8'h0A, 8'h0B);
    @(posedge clk);
    strobe <= 1'b1;
    cnt(8, ns, nq, nk);
    `CHK(ns + nq + nk, 0)
    `CHK(sink_enable, 1'b0)
    @(posedge clk);
    strobe <= 1'b0;
    u_host.wr(4'h4, 8'h2C, 8'hFF);
    repeat (2) @(posedge clk);
    #1;
    `CHK(sink_enable, 1'b1)
  endtask : t_constv
  task automatic t_strobe;
    int ns;
    int nq;
    int nk;
    for (int i = 0; i < 3; i++) begin
      u_host.wr(4'h7, (i == 0) ? 8'hC0 : (i == 1) ? 8'h80 : 8'h40, 8'hC0);
      @(posedge clk);
      strobe <= 1'b1;
      fork
        cnt(8, ns, nq, nk);
        begin
          repeat (3) @(posedge clk);
          strobe <= 1'b0;
        end
      join
      `CHK(nq, (i == 0) ? 3 : (i == 1) ? 1 : 0)
    end
  endtask : t_strobe
  // ==========================================================
  // Main sequence
  initial begin
    clk            = 1'b0;
    reset          = 1'b1;
    fault_set      = 8'h00;
    cycle_start    = 1'b0;
    uv_reduce      = 1'b0;
    uv_current     = 8'h00;
    actual_current = 8'h00;
    strobe         = 1'b0;
    bad_count      = 0;
    checked        = 0;
    cycles         = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset_vals();
    t_rw_mask();
    t_fault();
    t_min_cur();
    t_act_cur();
    t_pwm();
    t_skip();
    t_constv();
    t_strobe();
    print_verdict();
  end
endmodule : flash_driver_status_pwm_regs_bench
